// ### dv/rcl_reset_condition_logic_test.sv
`include "rcl_params.svh"

module rcl_reset_condition_logic_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rcl_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic por, pin_n, wdt, sleep, wake, busy, core_reset, pc_load, irq;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0] wsrc;
  logic [12:0] core_pc, pc_value;
  rcl_cause_e cause;
  logic [7:0] core_status, irq_control, option_config, port_b_dir, port_b_latch, mask;
  logic [4:0] port_a_dir, port_a_latch;
  int err_total, total_checks;

  rcl_reset_condition_logic #(.FILT_CYC(4)) uut (
    .CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .POR_PULSE(por), .EXT_RESET_PIN_N(pin_n), .WATCHDOG_TIMEOUT(wdt), .SLEEP_ACTIVE(sleep),
    .IRQ_WAKE(wake), .IRQ_WAKE_SRC(wsrc), .NVM_WRITE_BUSY(busy), .CORE_PC(core_pc),
    .CORE_RESET(core_reset), .PC_LOAD(pc_load), .PC_VALUE(pc_value), .CAUSE(cause),
    .CORE_STATUS(core_status), .IRQ_CONTROL(irq_control), .OPTION_CONFIG(option_config),
    .PORT_A_DIR(port_a_dir), .PORT_B_DIR(port_b_dir), .PORT_A_LATCH(port_a_latch),
    .PORT_B_LATCH(port_b_latch), .IRQ(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task results;
    $display("checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task tmo;
    err_total++;
    $display("unexpected wait: bound reached");
    results();
  endtask : tmo

  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rdata, exp);
  endtask : rd

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task pin_low(input int cyc);
    pin_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    pin_n <= 1'b1;
  endtask : pin_low

  task ev(input rcl_cause_e c, input logic [12:0] pc);
    int n;
    logic [7:0] bitv;
    bitv = 8'h01 << (c - 3'h1);
    n = 0;
    while (pc_load !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (pc_load !== 1'b1) tmo();
    chk("cause", 32'(cause), 32'(c));
    chk("pc value", 32'(pc_value), 32'(pc));
    n = 0;
    while (core_reset !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (core_reset !== 1'b0) tmo();
    repeat (3) @(posedge clk);
    chk("irq", 32'(irq), 32'((mask & bitv) != 8'h00));
    rd("event status", `RCL_IDX_EVT_STAT, 32'(bitv));
    repeat (2) @(posedge clk);
    chk("irq clear", 32'(irq), 32'h0);
  endtask : ev

  // ****************************************
  // Scenarios
  // ****************************************
  task t_por;
    ev(RCL_POR, 13'h0000);
    chk("status", 32'(core_status), 32'h18);
    chk("option", 32'(option_config), 32'hFF);
    chk("dir a", 32'(port_a_dir), 32'h1F);
    chk("dir b", 32'(port_b_dir), 32'hFF);
    chk("irq ctl", 32'(irq_control[7:1]), 32'h0);
    rd("pc low", `RCL_IDX_PC_LOW, 32'h0);
    rd("pc high", `RCL_IDX_PC_HIGH, 32'h0);
    wr(`RCL_IDX_EVT_MASK, 8'h2A);
    mask = 8'h2A;
    rd("mask", `RCL_IDX_EVT_MASK, 32'h2A);
    $display("test power-on done");
  endtask : t_por

  task t_regs;
    wr(`RCL_IDX_PC_HIGH, 8'hFF);
    rd("pc high width", `RCL_IDX_PC_HIGH, 32'h1F);
    rd("pc high alias", `RCL_IDX_PC_HIGH_B1, 32'h1F);
    wr(`RCL_IDX_CORE_STAT_B1, 8'hE5);
    @(posedge clk);
    chk("status alias", 32'(core_status), 32'hFD);
    rd("unmapped", 8'h07, 32'h0);
    chk("unmapped err", 32'(rerr), 32'h1);
    wr(`RCL_IDX_PA_DATA, 8'h15);
    wr(`RCL_IDX_PB_DATA, 8'hA5);
    wr(`RCL_IDX_OPTION, 8'h5A);
    wr(`RCL_IDX_PA_DIR, 8'h00);
    wr(`RCL_IDX_PB_DIR, 8'h00);
    wr(`RCL_IDX_IRQ_CTRL_B1, 8'h81);
    chk("option write", 32'(option_config), 32'h5A);
    $display("test registers done");
  endtask : t_regs

  task t_pin_run;
    int n;
    busy <= 1'b1;
    pin_low(2);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (pc_load === 1'b1) n++;
    end
    chk("short pulse", n, 32'h0);
    pin_low(12);
    ev(RCL_PIN_RUN, 13'h0000);
    busy <= 1'b0;
    chk("status", 32'(core_status), 32'h1D);
    chk("option", 32'(option_config), 32'hFF);
    chk("dir a", 32'(port_a_dir), 32'h1F);
    chk("dir b", 32'(port_b_dir), 32'hFF);
    chk("latch a", 32'(port_a_latch), 32'h15);
    chk("latch b", 32'(port_b_latch), 32'hA5);
    chk("irq ctl", 32'(irq_control), 32'h01);
    rd("nvm ctl", `RCL_IDX_NVM_CTRL, 32'h08);
    rd("pc high", `RCL_IDX_PC_HIGH, 32'h0);
    $display("test pin running done");
  endtask : t_pin_run

  task t_pin_sleep;
    sleep <= 1'b1;
    pin_low(12);
    ev(RCL_PIN_SLEEP, 13'h0000);
    sleep <= 1'b0;
    chk("status", 32'(core_status), 32'h15);
    $display("test pin sleeping done");
  endtask : t_pin_sleep

  task t_wdt;
    wr(`RCL_IDX_CORE_STAT, 8'hE7);
    wr(`RCL_IDX_OPTION, 8'h5A);
    wdt <= 1'b1;
    repeat (4) @(posedge clk);
    wdt <= 1'b0;
    ev(RCL_WDT_RUN, 13'h0000);
    chk("status", 32'(core_status), 32'h0F);
    chk("option", 32'(option_config), 32'hFF);
    wr(`RCL_IDX_CORE_STAT, 8'hE0);
    wr(`RCL_IDX_OPTION, 8'h5A);
    wr(`RCL_IDX_PC_HIGH, 8'h0A);
    wr(`RCL_IDX_IRQ_CTRL, 8'h08);
    core_pc <= 13'h0123;
    sleep <= 1'b1;
    wdt <= 1'b1;
    repeat (4) @(posedge clk);
    wdt <= 1'b0;
    ev(RCL_WDT_WAKE, 13'h0124);
    sleep <= 1'b0;
    chk("status", 32'(core_status), 32'hE0);
    chk("option", 32'(option_config), 32'h5A);
    chk("irq ctl", 32'(irq_control), 32'h08);
    rd("pc low", `RCL_IDX_PC_LOW, 32'h24);
    rd("pc high", `RCL_IDX_PC_HIGH, 32'h0A);
    $display("test watchdog done");
  endtask : t_wdt

  task t_irq_wake;
    core_pc <= 13'h0200;
    sleep <= 1'b1;
    wsrc <= 3'b100;
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    ev(RCL_IRQ_WAKE, 13'h0201);
    chk("status", 32'(core_status), 32'hF0);
    chk("irq ctl", 32'(irq_control), 32'h0C);
    wr(`RCL_IDX_IRQ_CTRL, 8'h80);
    wsrc <= 3'b010;
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    ev(RCL_IRQ_WAKE, `RCL_IRQ_VECTOR);
    sleep <= 1'b0;
    chk("irq ctl", 32'(irq_control), 32'h02);
    chk("latch a", 32'(port_a_latch), 32'h15);
    $display("test interrupt wake done");
  endtask : t_irq_wake

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, por, wdt, sleep, wake, busy} = '0;
    pin_n = 1'b1;
    paddr = '0;
    pwdata = '0;
    wsrc = '0;
    core_pc = '0;
    mask = '0;
    err_total = 0;
    total_checks = 0;
    arst_n = 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_por();
    t_regs();
    t_pin_run();
    t_pin_sleep();
    t_wdt();
    t_irq_wake();
    results();
  end
endmodule : rcl_reset_condition_logic_test

// ### include/rcl_params.svh
`ifndef RCL_PARAMS_SVH
`define RCL_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define RCL_CLK_MHZ 200
`define RCL_PIN_FILT_NS 2000
`define RCL_PIN_FILT_CYC ((`RCL_PIN_FILT_NS * `RCL_CLK_MHZ + 999) / 1000)

// ****************************************
// Register indexes, byte address = 4 * index
// ****************************************
`define RCL_IDX_IND_PORT 8'h00
`define RCL_IDX_TIMER 8'h01
`define RCL_IDX_PC_LOW 8'h02
`define RCL_IDX_CORE_STAT 8'h03
`define RCL_IDX_IND_PTR 8'h04
`define RCL_IDX_PA_DATA 8'h05
`define RCL_IDX_PB_DATA 8'h06
`define RCL_IDX_NVM_DATA 8'h08
`define RCL_IDX_NVM_ADDR 8'h09
`define RCL_IDX_PC_HIGH 8'h0A
`define RCL_IDX_IRQ_CTRL 8'h0B
`define RCL_IDX_WORK 8'h0C
`define RCL_IDX_IND_PORT_B1 8'h80
`define RCL_IDX_OPTION 8'h81
`define RCL_IDX_PC_LOW_B1 8'h82
`define RCL_IDX_CORE_STAT_B1 8'h83
`define RCL_IDX_IND_PTR_B1 8'h84
`define RCL_IDX_PA_DIR 8'h85
`define RCL_IDX_PB_DIR 8'h86
`define RCL_IDX_NVM_CTRL 8'h88
`define RCL_IDX_NVM_UNLOCK 8'h89
`define RCL_IDX_PC_HIGH_B1 8'h8A
`define RCL_IDX_IRQ_CTRL_B1 8'h8B
`define RCL_IDX_EVT_STAT 8'h8C
`define RCL_IDX_EVT_MASK 8'h8D

// ****************************************
// Reset values and fields
// ****************************************
`define RCL_RST_OPTION 8'hFF
`define RCL_RST_PA_DIR 5'h1F
`define RCL_RST_PB_DIR 8'hFF
`define RCL_RST_PC 13'h0000
`define RCL_IRQ_VECTOR 13'h0004
`define RCL_IRQ_EN_BIT 7

`endif

// ### include/rcl_pkg.sv
package rcl_pkg;

  typedef enum logic [2:0] {
    RCL_NONE, RCL_POR, RCL_PIN_RUN, RCL_PIN_SLEEP, RCL_WDT_RUN, RCL_WDT_WAKE, RCL_IRQ_WAKE
  } rcl_cause_e;

  typedef enum logic [4:0] {
    RG_NONE, RG_IND_PORT, RG_TIMER, RG_PC_LOW, RG_CORE_STAT, RG_IND_PTR, RG_PA_DATA,
    RG_PB_DATA, RG_NVM_DATA, RG_NVM_ADDR, RG_PC_HIGH, RG_IRQ_CTRL, RG_WORK, RG_OPTION,
    RG_PA_DIR, RG_PB_DIR, RG_NVM_CTRL, RG_NVM_UNLOCK, RG_EVT_STAT, RG_EVT_MASK
  } rcl_reg_e;

endpackage : rcl_pkg

// ### verilog/rcl_reset_condition_logic.sv
// Overview of operation
// - Each reset is power-on, pin running, pin sleeping, watchdog running, watchdog wake or interrupt wake.
// - Pin reset only after the pin stays low for the filter time.
// - Reset-independent registers have no reset and keep contents through every reset.
// - Non-wake resets load register reset states; watchdog wake leaves them untouched except status flags and pc low.
// - Power-on, pin and watchdog-running resets load program counter zero.
// - Watchdog or interrupt wake continues at program counter plus one.
// - Interrupt wake with global enable set loads the interrupt vector.
// - Timeout and power-down flags and status top bits follow the reset cause.
// - Non-wake resets: option and port B direction all ones, port A direction ones.
// - Irq control clears upper seven bits; nvm control clears except condition bit.
// - Interrupt wake sets the irq control flag bits of the wake source.
// - Non-wake resets return pins to inputs; port data latches keep their contents.
// - Unimplemented bits read zero; condition bits follow the reset cause.
// - Global interrupt enable, irq control bit 7, clears on every non-wake reset and when interrupt wake takes the vector.
//
// The APB interface to the registers was decided locally.
`include "rcl_params.svh"

module rcl_reset_condition_logic #(
  parameter int ADDR_W = 10,
  parameter int FILT_CYC = `RCL_PIN_FILT_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Reset sources, asynchronous
  input wire logic POR_PULSE,
  input wire logic EXT_RESET_PIN_N,
  input wire logic WATCHDOG_TIMEOUT,
  // Core state, same clock
  input wire logic SLEEP_ACTIVE,
  input wire logic IRQ_WAKE,
  input wire logic [2:0] IRQ_WAKE_SRC,
  input wire logic NVM_WRITE_BUSY,
  input wire logic [12:0] CORE_PC,
  // Core control
  output logic CORE_RESET,
  output logic PC_LOAD,
  output logic [12:0] PC_VALUE,
  output rcl_pkg::rcl_cause_e CAUSE,
  output logic [7:0] CORE_STATUS,
  output logic [7:0] IRQ_CONTROL,
  output logic [7:0] OPTION_CONFIG,
  // Ports
  output logic [4:0] PORT_A_DIR,
  output logic [7:0] PORT_B_DIR,
  output logic [4:0] PORT_A_LATCH,
  output logic [7:0] PORT_B_LATCH,
  // Interrupt
  output logic IRQ
);
  import rcl_pkg::*;

  localparam int CNT_W = $clog2(FILT_CYC + 1);
  localparam logic [2:0] SYNC_RST = 3'h2;

  // ****************************************
  // Register decode
  // ****************************************
  function automatic rcl_reg_e reg_dec(input logic [7:0] idx);
    case (idx)
      `RCL_IDX_IND_PORT, `RCL_IDX_IND_PORT_B1: reg_dec = RG_IND_PORT;
      `RCL_IDX_PC_LOW, `RCL_IDX_PC_LOW_B1: reg_dec = RG_PC_LOW;
      `RCL_IDX_CORE_STAT, `RCL_IDX_CORE_STAT_B1: reg_dec = RG_CORE_STAT;
      `RCL_IDX_IND_PTR, `RCL_IDX_IND_PTR_B1: reg_dec = RG_IND_PTR;
      `RCL_IDX_PC_HIGH, `RCL_IDX_PC_HIGH_B1: reg_dec = RG_PC_HIGH;
      `RCL_IDX_IRQ_CTRL, `RCL_IDX_IRQ_CTRL_B1: reg_dec = RG_IRQ_CTRL;
      `RCL_IDX_TIMER: reg_dec = RG_TIMER;
      `RCL_IDX_PA_DATA: reg_dec = RG_PA_DATA;
      `RCL_IDX_PB_DATA: reg_dec = RG_PB_DATA;
      `RCL_IDX_NVM_DATA: reg_dec = RG_NVM_DATA;
      `RCL_IDX_NVM_ADDR: reg_dec = RG_NVM_ADDR;
      `RCL_IDX_WORK: reg_dec = RG_WORK;
      `RCL_IDX_OPTION: reg_dec = RG_OPTION;
      `RCL_IDX_PA_DIR: reg_dec = RG_PA_DIR;
      `RCL_IDX_PB_DIR: reg_dec = RG_PB_DIR;
      `RCL_IDX_NVM_CTRL: reg_dec = RG_NVM_CTRL;
      `RCL_IDX_NVM_UNLOCK: reg_dec = RG_NVM_UNLOCK;
      `RCL_IDX_EVT_STAT: reg_dec = RG_EVT_STAT;
      `RCL_IDX_EVT_MASK: reg_dec = RG_EVT_MASK;
      default: reg_dec = RG_NONE;
    endcase
  endfunction : reg_dec

  // Slot of a reset-independent register
  function automatic logic [2:0] slot_of(input rcl_reg_e r);
    case (r)
      RG_TIMER: slot_of = 3'h0;
      RG_IND_PTR: slot_of = 3'h1;
      RG_PA_DATA: slot_of = 3'h2;
      RG_PB_DATA: slot_of = 3'h3;
      RG_NVM_DATA: slot_of = 3'h4;
      RG_NVM_ADDR: slot_of = 3'h5;
      default: slot_of = 3'h6;
    endcase
  endfunction : slot_of

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sync_in;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;

  assign sync_in = {WATCHDOG_TIMEOUT, EXT_RESET_PIN_N, POR_PULSE};

  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        sync1_q[i] <= SYNC_RST[i];
        sync2_q[i] <= SYNC_RST[i];
      end else begin
        sync1_q[i] <= sync_in[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic por_s;
  logic pin_s;
  logic wdt_s;
  assign por_s = sync2_q[0];
  assign pin_s = sync2_q[1];
  assign wdt_s = sync2_q[2];

  // ****************************************
  // Pin filter and cause detection
  // ****************************************
  logic [CNT_W-1:0] flt_cnt_q;
  logic pin_low_q;
  logic por_q;
  logic wdt_d_q;
  rcl_cause_e pin_cause_q;
  logic pin_hit;
  logic busy;
  logic pin_rel;
  logic por_go;
  logic wdt_rise;
  rcl_cause_e ev;
  logic ev_reset;
  logic ev_wake;

  assign pin_hit = !pin_s && !pin_low_q && (flt_cnt_q == CNT_W'(FILT_CYC - 1));
  assign busy = por_q || pin_low_q;
  assign por_go = por_q && !pin_low_q && !por_s;
  assign pin_rel = pin_low_q && pin_s && !por_q;
  assign wdt_rise = wdt_s && !wdt_d_q;

  assign ev = por_go ? RCL_POR :
              pin_rel ? pin_cause_q :
              (wdt_rise && !busy) ? (SLEEP_ACTIVE ? RCL_WDT_WAKE : RCL_WDT_RUN) :
              (IRQ_WAKE && SLEEP_ACTIVE && !busy) ? RCL_IRQ_WAKE : RCL_NONE;
  assign ev_wake = (ev == RCL_WDT_WAKE) || (ev == RCL_IRQ_WAKE);
  assign ev_reset = (ev != RCL_NONE) && !ev_wake;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flt_cnt_q <= '0;
      pin_low_q <= 1'b0;
      por_q <= 1'b1;
      wdt_d_q <= 1'b0;
      pin_cause_q <= RCL_PIN_RUN;
    end else begin
      flt_cnt_q <= (pin_s || pin_low_q) ? '0 : flt_cnt_q + CNT_W'(1);
      pin_low_q <= pin_s ? 1'b0 : (pin_low_q || pin_hit);
      por_q <= por_s || (por_q && !por_go);
      wdt_d_q <= wdt_s;
      if (pin_hit) begin
        pin_cause_q <= SLEEP_ACTIVE ? RCL_PIN_SLEEP : RCL_PIN_RUN;
      end
    end
  end

  // ****************************************
  // APB access
  // ****************************************
  rcl_reg_e sel;
  logic setup;
  logic acc;
  logic wr_en;
  logic [7:0] wd;

  assign sel = reg_dec(PADDR[9:2]);
  assign setup = PSEL && !PENABLE;
  assign acc = PSEL && PENABLE && PREADY;
  assign wr_en = acc && PWRITE && !busy;
  assign wd = PWDATA[7:0];

  // ****************************************
  // Reset-state registers
  // ****************************************
  logic [7:0] stat_q;
  logic [7:0] pc_low_q;
  logic [4:0] pc_high_q;
  logic [7:0] irq_ctl_q;
  logic [7:0] option_q;
  logic [4:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic [3:0] nvm_q;
  logic [7:0] stat_d;
  logic [7:0] irq_ctl_d;
  logic [12:0] pc_d;
  logic vec_take;

  assign vec_take = (ev == RCL_IRQ_WAKE) && irq_ctl_q[`RCL_IRQ_EN_BIT];
  assign pc_d = vec_take ? `RCL_IRQ_VECTOR :
                ev_wake ? CORE_PC + 13'h0001 : `RCL_RST_PC;

  assign stat_d = (ev == RCL_POR) ? {3'h0, 2'b11, stat_q[2:0]} :
                  (ev == RCL_PIN_RUN) ? {3'h0, stat_q[4:0]} :
                  (ev == RCL_PIN_SLEEP) ? {3'h0, 2'b10, stat_q[2:0]} :
                  (ev == RCL_WDT_RUN) ? {3'h0, 2'b01, stat_q[2:0]} :
                  (ev == RCL_WDT_WAKE) ? {stat_q[7:5], 2'b00, stat_q[2:0]} :
                  (ev == RCL_IRQ_WAKE) ? {stat_q[7:5], 2'b10, stat_q[2:0]} :
                  (wr_en && sel == RG_CORE_STAT) ? {wd[7:5], stat_q[4:3], wd[2:0]} : stat_q;

  assign irq_ctl_d = ev_reset ? {7'h00, irq_ctl_q[0]} :
                     (ev == RCL_IRQ_WAKE) ?
                       {irq_ctl_q[7] && !vec_take, irq_ctl_q[6:3], irq_ctl_q[2:0] | IRQ_WAKE_SRC} :
                     (wr_en && sel == RG_IRQ_CTRL) ? wd : irq_ctl_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      stat_q <= 8'h18;
      irq_ctl_q <= 8'h00;
      pc_low_q <= 8'h00;
      pc_high_q <= 5'h00;
      option_q <= `RCL_RST_OPTION;
      dir_a_q <= `RCL_RST_PA_DIR;
      dir_b_q <= `RCL_RST_PB_DIR;
      nvm_q <= 4'h0;
    end else begin
      stat_q <= stat_d;
      irq_ctl_q <= irq_ctl_d;
      if (ev_reset) begin
        pc_low_q <= 8'h00;
        pc_high_q <= 5'h00;
        option_q <= `RCL_RST_OPTION;
        dir_a_q <= `RCL_RST_PA_DIR;
        dir_b_q <= `RCL_RST_PB_DIR;
        nvm_q <= {NVM_WRITE_BUSY, 3'h0};
      end else if (ev_wake) begin
        pc_low_q <= pc_d[7:0];
      end else if (wr_en) begin
        if (sel == RG_PC_LOW) pc_low_q <= wd;
        if (sel == RG_PC_HIGH) pc_high_q <= wd[4:0];
        if (sel == RG_OPTION) option_q <= wd;
        if (sel == RG_PA_DIR) dir_a_q <= wd[4:0];
        if (sel == RG_PB_DIR) dir_b_q <= wd;
        if (sel == RG_NVM_CTRL) nvm_q <= wd[3:0];
      end
    end
  end

  // ****************************************
  // Reset-independent storage
  // ****************************************
  logic [7:0] indep_q [0:6];
  logic indep_wr;

  assign indep_wr = wr_en && (sel inside {RG_TIMER, RG_IND_PTR, RG_PA_DATA, RG_PB_DATA,
                                          RG_NVM_DATA, RG_NVM_ADDR, RG_WORK});

  always_ff @(posedge CLK) begin
    if (indep_wr) indep_q[slot_of(sel)] <= wd;
  end

  // ****************************************
  // Event status and interrupt
  // ****************************************
  logic [5:0] evt_q;
  logic [5:0] mask_q;
  logic [5:0] evt_set;
  logic [5:0] evt_d;
  logic evt_rd;

  assign evt_set = {ev == RCL_IRQ_WAKE, ev == RCL_WDT_WAKE, ev == RCL_WDT_RUN,
                    ev == RCL_PIN_SLEEP, ev == RCL_PIN_RUN, ev == RCL_POR};
  assign evt_rd = acc && !PWRITE && (sel == RG_EVT_STAT);
  assign evt_d = evt_set | (evt_q & {6{!evt_rd}});

  // ****************************************
  // Read mux
  // ****************************************
  logic [7:0] rd_data;

  assign rd_data = (sel == RG_PC_LOW) ? pc_low_q :
                   (sel == RG_CORE_STAT) ? stat_q :
                   (sel == RG_PC_HIGH) ? {3'h0, pc_high_q} :
                   (sel == RG_IRQ_CTRL) ? irq_ctl_q :
                   (sel == RG_OPTION) ? option_q :
                   (sel == RG_PA_DIR) ? {3'h0, dir_a_q} :
                   (sel == RG_PB_DIR) ? dir_b_q :
                   (sel == RG_NVM_CTRL) ? {4'h0, nvm_q} :
                   (sel == RG_PA_DATA) ? {3'h0, indep_q[2][4:0]} :
                   (sel == RG_EVT_STAT) ? {2'h0, evt_q} :
                   (sel == RG_EVT_MASK) ? {2'h0, mask_q} :
                   (sel inside {RG_TIMER, RG_IND_PTR, RG_PB_DATA, RG_NVM_DATA, RG_NVM_ADDR, RG_WORK}) ?
                     indep_q[slot_of(sel)] : 8'h00;

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      evt_q <= 6'h00;
      mask_q <= 6'h00;
      IRQ <= 1'b0;
      CORE_RESET <= 1'b1;
      PC_LOAD <= 1'b0;
      PC_VALUE <= `RCL_RST_PC;
      CAUSE <= RCL_NONE;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && (sel == RG_NONE);
      PRDATA <= (setup && !PWRITE) ? {24'h00_0000, rd_data} : 32'h0000_0000;
      evt_q <= evt_d;
      if (wr_en && sel == RG_EVT_MASK) mask_q <= wd[5:0];
      IRQ <= |(evt_d & mask_q);
      CORE_RESET <= por_q || pin_low_q || pin_hit || por_s;
      PC_LOAD <= (ev != RCL_NONE);
      if (ev != RCL_NONE) begin
        PC_VALUE <= pc_d;
        CAUSE <= ev;
      end
    end
  end

  assign CORE_STATUS = stat_q;
  assign IRQ_CONTROL = irq_ctl_q;
  assign OPTION_CONFIG = option_q;
  assign PORT_A_DIR = dir_a_q;
  assign PORT_B_DIR = dir_b_q;
  assign PORT_A_LATCH = indep_q[2][4:0];
  assign PORT_B_LATCH = indep_q[3];

  // ****************************************
  // Assertions
  // ****************************************
  a_por_pc_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ev == RCL_POR) |=> PC_LOAD && PC_VALUE == 13'h0000 && CAUSE == RCL_POR)
    else $error("power-on did not load program counter zero");

  a_wake_pc_next: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ev == RCL_WDT_WAKE) |=> PC_VALUE == $past(CORE_PC) + 13'h0001 && pc_low_q == PC_VALUE[7:0])
    else $error("watchdog wake did not continue at next address");

  a_vector_load: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ev == RCL_IRQ_WAKE && irq_ctl_q[7]) |=> PC_VALUE == 13'h0004 && !irq_ctl_q[7])
    else $error("interrupt wake did not take the vector");

  a_por_flags: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ev == RCL_POR) |=> stat_q[7:3] == 5'b00011 && $stable(stat_q[2:0]))
    else $error("power-on status flags wrong");

  a_wdt_flags: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ev == RCL_WDT_RUN) ##1 !(ev inside {RCL_POR, RCL_PIN_RUN, RCL_PIN_SLEEP, RCL_IRQ_WAKE, RCL_WDT_WAKE})
      |-> stat_q[4:3] == 2'b01 && stat_q[7:5] == 3'h0)
    else $error("watchdog reset flags wrong");

  a_dir_inputs: assert property (@(posedge CLK) disable iff (!ARST_N)
    ev_reset |=> dir_a_q == 5'h1F && dir_b_q == 8'hFF && option_q == 8'hFF && pc_high_q == 5'h00)
    else $error("reset did not return pins to input");

  a_sleep_keep: assert property (@(posedge CLK) disable iff (!ARST_N)
    (ev == RCL_WDT_WAKE) |=> $stable(option_q) && $stable(dir_b_q) && $stable(irq_ctl_q))
    else $error("watchdog wake disturbed registers");

  a_irq_en_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
    ev_reset |=> irq_ctl_q[7:1] == 7'h00 && irq_ctl_q[0] == $past(irq_ctl_q[0]))
    else $error("irq control not cleared on reset");

  a_pin_filter: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(pin_low_q) |-> $past(!pin_s, 1) && $past(!pin_s, 2) && $past(!pin_s, 3) && $past(!pin_s, 4))
    else $error("short pin pulse caused a reset");

endmodule : rcl_reset_condition_logic
